/* asw_host.sv */
// host controller driving an asynchronous static ram through its pins
// assumes one request at a time; req is a level taken while ready is high
`timescale 1ns/1ns
// Operation
// - hold output enable high to float pins
// - strobe high during every address change
// - drive data only after memory releases pins
// - retention needs only select held high
module asw_host
   import asw_pkg::*;
#(
   parameter int AW = 15,
   parameter int DW = 8
) (
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   input  wire logic          clk_en,
   input  wire logic          req,
   input  wire logic          req_write,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [DW-1:0] req_wdata,
   output logic               ready,
   output logic               rd_valid,
   output logic [DW-1:0]      rd_data,
   output logic [AW-1:0]      mem_addr,
   output logic               chip_select_n,
   output logic               write_enable_n,
   output logic               output_enable_n,
   output logic [DW-1:0]      data_out,
   output logic               data_oe,
   input  wire logic [DW-1:0] data_in
);
   typedef struct packed {
      asw_state_e    state;
      logic [CNT_W-1:0] cnt;
      logic          is_write;
      logic          rdy;
      logic          rvalid;
      logic [DW-1:0] rdata;
      logic [AW-1:0] addr;
      logic          cs_n;
      logic          we_n;
      logic          oe_n;
      logic [DW-1:0] dout;
      logic          doe;
   } asw_host_s;

   asw_host_s st, next_st;
   asw_sync_if #(.DW(DW)) pins ();

   asw_sync #(.DW(DW)) u_sync (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .pin_in  (data_in),
      .sync    (pins)
   );

   always_comb begin
      next_st        = st;
      next_st.rvalid = 1'b0;
      case (st.state)
         ASW_IDLE: begin
            // strobes are all high here, so the address may move safely
            if (req && st.rdy) begin
               next_st.addr     = req_addr;
               next_st.is_write = req_write;
               next_st.dout     = req_wdata;
               next_st.rdy      = 1'b0;
               next_st.oe_n     = 1'b1;
               if (req_write) begin
                  // wait out a possible read drive before turning the bus round
                  next_st.cnt   = HZ_CNT;
                  next_st.state = ASW_TURN;
               end else begin
                  next_st.cs_n  = 1'b0;
                  next_st.oe_n  = 1'b0;
                  next_st.cnt   = RC_CNT;
                  next_st.state = ASW_RPULSE;
               end
            end
         end
         ASW_TURN: begin
            if (st.cnt == CNT_ONE) begin
               // write strobe first, select after: pins stay floating
               next_st.we_n  = 1'b0;
               next_st.state = ASW_SETUP;
            end else begin
               next_st.cnt = st.cnt - CNT_ONE;
            end
         end
         ASW_SETUP: begin
            next_st.doe   = 1'b1;
            next_st.cs_n  = 1'b0;
            next_st.cnt   = WP_CNT;
            next_st.state = ASW_WPULSE;
         end
         ASW_WPULSE: begin
            if (st.cnt == CNT_ONE) begin
               // end the overlap with both strobes; data holds one more cycle
               next_st.we_n  = 1'b1;
               next_st.cs_n  = 1'b1;
               next_st.state = ASW_WEND;
            end else begin
               next_st.cnt = st.cnt - CNT_ONE;
            end
         end
         ASW_WEND: begin
            next_st.doe   = 1'b0;
            next_st.rdy   = 1'b1;
            next_st.state = ASW_IDLE;
         end
         ASW_RPULSE: begin
            if (st.cnt == CNT_ONE) begin
               // sample late: the synchroniser adds two cycles of delay
               next_st.rdata  = pins.rd_data;
               next_st.cs_n   = 1'b1;
               next_st.oe_n   = 1'b1;
               next_st.state  = ASW_REND;
            end else begin
               next_st.cnt = st.cnt - CNT_ONE;
            end
         end
         ASW_REND: begin
            next_st.rvalid = 1'b1;
            next_st.rdy    = 1'b1;
            next_st.state  = ASW_IDLE;
         end
         default: begin
            next_st.state = ASW_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st       <= '0;
         st.state <= ASW_IDLE;
         st.rdy   <= 1'b1;
         st.cs_n  <= 1'b1;
         st.we_n  <= 1'b1;
         st.oe_n  <= 1'b1;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign ready           = st.rdy;
   assign rd_valid        = st.rvalid;
   assign rd_data         = st.rdata;
   assign mem_addr        = st.addr;
   assign chip_select_n   = st.cs_n;
   assign write_enable_n  = st.we_n;
   assign output_enable_n = st.oe_n;
   assign data_out        = st.dout;
   assign data_oe         = st.doe;

   a_overlap_only_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!chip_select_n && !write_enable_n) |-> st.is_write)
      else $error("write overlap during a read");
   a_we_data_float: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!write_enable_n) |-> output_enable_n)
      else $error("output enable low while write strobe low");
   a_read_select: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!output_enable_n) |-> (!chip_select_n && write_enable_n))
      else $error("output enable without read select");
   a_oe_before_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
      data_oe |-> output_enable_n)
      else $error("host drives while memory may drive");
   a_we_leads_cs: assert property (@(posedge sys_clk) disable iff (!resetn)
      ($fell(chip_select_n) && st.is_write) |-> $past(!write_enable_n))
      else $error("select fell before write strobe");
   // a read may move the address with select low, as long as the write strobe stays high
   a_addr_stable: assert property (@(posedge sys_clk) disable iff (!resetn)
      $changed(mem_addr) |->
         ((chip_select_n || write_enable_n) && $past(chip_select_n || write_enable_n)))
      else $error("address moved during strobe");
   // reaches back to the first turnaround cycle, so a skipped wait after a read is caught
   a_turn_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(data_oe) |-> $past(output_enable_n, HZ_CYC + 1))
      else $error("drive too soon after read");
   a_idle_deselect: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st.state == ASW_IDLE) |-> chip_select_n)
      else $error("select low while idle");
   a_pulse_width: assert property (@(posedge sys_clk) disable iff (!resetn)
      ($fell(chip_select_n) && st.is_write && clk_en) |-> !write_enable_n [*2])
      else $error("write pulse too short");
   a_read_done: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st.state == ASW_RPULSE && clk_en) |-> ##[1:40] rd_valid)
      else $error("read never completed");

   c_write: cover property (@(posedge sys_clk) st.state == ASW_WEND);
   c_read: cover property (@(posedge sys_clk) rd_valid);
   c_back: cover property (@(posedge sys_clk) rd_valid ##1 (req && req_write && ready));
endmodule

/* asw_pkg.sv */
// package for the asynchronous sram host write/read controller
// assumes a 125 MHz system clock; the write pulse, read cycle and bus release times in ns are turned into cycles here
package asw_pkg;
   localparam int unsigned CLK_PERIOD_NS = 8;
   // write and read cycle figures, slowest grade at 3.0 V
   localparam int unsigned T_WC_NS  = 120;
   localparam int unsigned T_WP_NS  = 80;
   localparam int unsigned T_DW_NS  = 70;
   localparam int unsigned T_WHZ_NS = 40;
   localparam int unsigned T_RC_NS  = 120;
   // least times round up to whole cycles
   localparam int unsigned WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RC_CYC  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HZ_CYC  = (T_WHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W   = 5;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
   localparam logic [CNT_W-1:0] WP_CNT   = CNT_W'(WP_CYC);
   localparam logic [CNT_W-1:0] RC_CNT   = CNT_W'(RC_CYC);
   localparam logic [CNT_W-1:0] HZ_CNT   = CNT_W'(HZ_CYC);
   typedef enum logic [2:0] {
      ASW_IDLE, ASW_TURN, ASW_SETUP, ASW_WPULSE, ASW_WEND, ASW_RPULSE, ASW_REND
   } asw_state_e;
endpackage

/* asw_sync_if.sv */
// interface carrying the data pin sample from the synchroniser to the controller
// assumes both ends run on the same sys_clk
`timescale 1ns/1ns
interface asw_sync_if #(parameter int DW = 8);
   logic [DW-1:0] rd_data;
   modport src (output rd_data);
   modport dst (input  rd_data);
endinterface

/* asw_sync.sv */
// two flip-flop synchroniser for the sram data pins
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/1ns
module asw_sync
   import asw_pkg::*;
#(
   parameter int DW = 8
) (
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   input  wire logic          clk_en,
   input  wire logic [DW-1:0] pin_in,
   asw_sync_if.src            sync
);
   typedef struct packed {
      logic [DW-1:0] meta;
      logic [DW-1:0] stable;
   } asw_sync_s;
   asw_sync_s st, next_st;
   always_comb begin
      next_st        = st;
      next_st.meta   = pin_in;
      next_st.stable = st.meta;
   end
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end
   assign sync.rd_data = st.stable;
endmodule

/* asw_sram_model.sv */
// behavioural model of the asynchronous static ram on the far side of the host
// assumes the bench resolves the shared data wire from both enables
`timescale 1ns/1ns
module asw_sram_model #(
   parameter int AW = 15,
   parameter int DW = 8
) (
   input  wire logic [AW-1:0] addr,
   input  wire logic          chip_select_n,
   input  wire logic          write_enable_n,
   input  wire logic          output_enable_n,
   input  wire logic [DW-1:0] dq_in,
   output logic [DW-1:0]      dq_out,
   output logic               dq_oe
);
   logic [DW-1:0] store [2**AW];
   // cell follows the pins during the overlap, so the last value before release stays
   always @* begin
      if (!chip_select_n && !write_enable_n) begin
         store[addr] = dq_in;
      end
   end
   // a low write strobe floats the pins whatever the output enable says
   assign dq_oe  = !chip_select_n && write_enable_n && !output_enable_n;
   assign dq_out = store[addr];
endmodule

/* testbench.sv */
// self-checking bench for the sram host controller against a behavioural memory
// assumes the host takes a request while ready is high and answers within 60 cycles
`timescale 1ns/1ns
module testbench;
   import asw_pkg::*;
   logic          sys_clk = 1'b0;
   logic          resetn = 1'b0;
   logic          clk_en = 1'b1;
   logic          req = 1'b0;
   logic          req_write = 1'b0;
   logic [14:0]   req_addr = 15'h0000;
   logic [7:0]    req_wdata = 8'h00;
   logic          ready, rd_valid, chip_select_n, write_enable_n, output_enable_n, data_oe;
   logic [7:0]    rd_data, data_out, m_dq, pins;
   logic [7:0]    float_v = 8'hA5;
   logic [14:0]   mem_addr, prev_addr, addr_tab [8];
   logic          m_oe, prev_str;
   logic [7:0]    ref_mem [int];
   int            err_total = 0;
   int            samples_checked = 0;
   int            cycles = 0;

   always #4 sys_clk = ~sys_clk;
   // released pins show a changing pattern so a stale value is never read back
   assign pins = data_oe ? data_out : (m_oe ? m_dq : float_v);

   asw_host asw_host_i (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .ready(ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .mem_addr(mem_addr),
      .chip_select_n(chip_select_n), .write_enable_n(write_enable_n),
      .output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe),
      .data_in(pins));
   asw_sram_model asw_sram_model_i (.addr(mem_addr), .chip_select_n(chip_select_n),
      .write_enable_n(write_enable_n), .output_enable_n(output_enable_n), .dq_in(pins),
      .dq_out(m_dq), .dq_oe(m_oe));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic op(input logic w, input logic [14:0] a, input logic [7:0] d);
      int n;
      int fz;
      n = 0;
      fz = $urandom % 4;
      req <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do @(posedge sys_clk); while (!(ready && clk_en));
      req <= 1'b0;
      // a short freeze right after the take may only delay the transfer
      if (fz > 0) begin
         clk_en <= 1'b0;
         repeat (fz) @(posedge sys_clk);
         clk_en <= 1'b1;
      end
      do begin
         @(posedge sys_clk);
         n++;
      end while (!(w ? ready : rd_valid) && n < 60);
      check("done", 32'(n < 60), 32'h1);
      check("latency", 32'(n), w ? 32'(HZ_CYC + WP_CYC + 3) : 32'(RC_CYC + 2));
      if (w)
         ref_mem[a] = d;
      else
         check("rd_data", 32'(rd_data), 32'(ref_mem[a]));
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      float_v <= ~float_v;
      if (resetn) begin
         check("contention", 32'(data_oe & m_oe), 32'h0);
         if (data_oe)
            check("oe_n_float", 32'(output_enable_n), 32'h1);
         if (mem_addr !== prev_addr)
            check("addr_strobe", 32'((chip_select_n | write_enable_n) & prev_str), 32'h1);
         if (ready)
            check("idle_cs_n", 32'(chip_select_n), 32'h1);
      end
      prev_addr <= mem_addr;
      prev_str <= chip_select_n | write_enable_n;
      if (cycles > 5000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      void'($urandom(32'h18D0));
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      // corner addresses at both ends of the range, the rest random
      for (int i = 0; i < 8; i++) begin
         addr_tab[i] = (i == 0) ? 15'h0000 : (i == 7) ? 15'h7FFF : 15'($urandom);
         op(1'b1, addr_tab[i], 8'($urandom));
      end
      op(1'b1, addr_tab[7], 8'hFF);
      op(1'b0, addr_tab[7], 8'h00);
      repeat (60) op(1'($urandom), addr_tab[$urandom % 8], 8'($urandom));
      // a frozen block must neither take a request nor apply it later
      clk_en <= 1'b0;
      req <= 1'b1;
      req_write <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check("frz_ready", 32'(ready), 32'h1);
      check("frz_cs_n", 32'(chip_select_n), 32'h1);
      req <= 1'b0;
      clk_en <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check("frz_idle", 32'(ready), 32'h1);
      end_sim();
   end
endmodule
